// ### core/lacs_regbank.sv
`timescale 1ns/1ns
module lacs_regbank (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // register access
  lacs_reg_if.bank  rb
);
  import lacs_pkg::*;

  logic [7:0] rd_q;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic [7:0] r_q;
      wire        hit = rb.wr_en && (rb.wr_addr == 8'(g));
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          r_q <= REG_RST;
        end else if (hit) begin
          r_q <= rb.wr_data & REG_MASK[g];
        end
      end
      assign rb.regs[g] = r_q;
    end
  endgenerate

  // unmapped offsets read as zero
  wire       rd_hit = rb.rd_addr < 8'(NREG);
  wire [7:0] rd_d   = rd_hit ? rb.regs[rb.rd_addr[3:0]] : 8'h00;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rb.rd_data = rd_q;

endmodule // lacs_regbank

// ### core/lacs_top.sv
`timescale 1ns/1ns
// Operation
// (R1) offset cancel bypass bit turns loop off
// (R2) slice level register drives threshold trim
// (R3) swing code selects 300, 600, 900 mV
// (R4) codes 00, 01, 11 map to swings
// (R5) emphasis code sets 0..8 dB, 1 dB steps
// (R6) four-bit bandwidth code picks 16 filters
// (R7) two pins pick among four bandwidth sources
// (R8) pin states map to defaults and registers
// (R9) custom bit picks register code over default
// (R10) open pins read high/low, selecting source d
// (R11) range bit picks high or low detect range
// (R12) seven-bit code sets detect threshold
// (R13) pin states map to detect defaults, registers
// (R14) custom bit picks register detect code
// (R15) open pins select detect source d
// (R16) absent flag when amplitude below threshold
// (R17) effective codes follow pins and registers
// (R18) code zero widest, fifteen narrowest bandwidth
module lacs_top #(
  parameter logic [6:0] SDET_DEF_A = 7'h00,
  parameter logic [6:0] SDET_DEF_B = 7'h13,
  parameter logic [6:0] SDET_DEF_C = 7'h46,
  parameter logic [6:0] SDET_DEF_D = 7'h46
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // two-wire serial port
  input  wire logic       SCK,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  // bandwidth select pins and open-pin sense
  input  wire logic       BW_PIN_HI,
  input  wire logic       BW_PIN_LO,
  input  wire logic       BW_PIN_HI_OPEN,
  input  wire logic       BW_PIN_LO_OPEN,
  // detected input amplitude, threshold scale
  input  wire logic [6:0] SIG_LEVEL,
  // analog control codes
  output logic            OFFSET_CANCEL_OFF,
  output logic [7:0]      SLICE_LEVEL_CODE,
  output logic [3:0]      EMPHASIS_CODE,
  output logic [1:0]      SWING_CODE,
  output logic [2:0]      SWING_SEL,
  output logic            OUTPUT_MUTE,
  output logic [3:0]      BW_CODE,
  output logic            SIGDET_RANGE_HI,
  output logic [6:0]      SIGDET_CODE,
  output logic            SIGNAL_ABSENT
);
  import lacs_pkg::*;

  lacs_reg_if rif ();

  lacs_regbank u_bank (
    .CLK (CLK),
    .RST (RST),
    .rb  (rif.bank)
  );

  // serial slave

  logic        scl_q;
  logic        scl_p;
  logic        sda_q;
  logic        sda_p;
  lacs_state_t state_q;
  lacs_state_t state_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic        rw_q;
  logic        rw_d;
  logic        drv_q;
  logic        drv_d;

  // inputs are clock-synchronous; one stage more gives edge history
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_q <= 1'b1;
      scl_p <= 1'b1;
      sda_q <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= SCK;
      scl_p <= scl_q;
      sda_q <= SDA_I;
      sda_p <= sda_q;
    end
  end

  wire scl_rise = scl_q & ~scl_p;
  wire scl_fall = ~scl_q & scl_p;
  wire start_c  = scl_q & scl_p & sda_p & ~sda_q;
  wire stop_c   = scl_q & scl_p & ~sda_p & sda_q;
  wire byte_in  = cnt_q == BYTE_BITS;
  wire shift_in = scl_rise && !byte_in;
  wire addr_hit = sh_q[7:1] == DEV_ADDR;

  // commit on the falling edge that closes the data byte
  assign rif.wr_en   = scl_fall && byte_in && (state_q == ST_WDATA);
  assign rif.wr_addr = ptr_q;
  assign rif.wr_data = sh_q;
  assign rif.rd_addr = ptr_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    drv_d   = drv_q;
    if (stop_c) begin
      state_d = ST_IDLE;
      drv_d   = 1'b0;
    end else if (start_c) begin
      // a repeated start restarts framing at any point
      state_d = ST_DEVADR;
      cnt_d   = 4'h0;
      drv_d   = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          drv_d = 1'b0;
        end
        ST_DEVADR: begin
          if (shift_in) begin
            sh_d  = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && byte_in) begin
            if (addr_hit) begin
              drv_d   = 1'b1;
              rw_d    = sh_q[0];
              state_d = ST_ACKDEV;
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ACKDEV: begin
          if (scl_fall) begin
            if (rw_q) begin
              // read returns the byte at the last written pointer
              sh_d    = rif.rd_data;
              drv_d   = ~rif.rd_data[7];
              cnt_d   = 4'h1;
              state_d = ST_RDATA;
            end else begin
              drv_d   = 1'b0;
              cnt_d   = 4'h0;
              state_d = ST_REGADR;
            end
          end
        end
        ST_REGADR: begin
          if (shift_in) begin
            sh_d  = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && byte_in) begin
            ptr_d   = sh_q;
            drv_d   = 1'b1;
            state_d = ST_ACKREG;
          end
        end
        ST_ACKREG: begin
          if (scl_fall) begin
            drv_d   = 1'b0;
            cnt_d   = 4'h0;
            state_d = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (shift_in) begin
            sh_d  = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && byte_in) begin
            drv_d   = 1'b1;
            state_d = ST_ACKDAT;
          end
        end
        ST_ACKDAT: begin
          // one data byte per transfer; further bytes are not acknowledged
          if (scl_fall) begin
            drv_d   = 1'b0;
            state_d = ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (byte_in) begin
              drv_d   = 1'b0;
              state_d = ST_RACK;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_d = ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          drv_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
          drv_d   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      drv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      drv_q   <= drv_d;
    end
  end

  // open drain: only ever pulls low
  assign SDA_O  = 1'b0;
  assign SDA_OE = drv_q;

  // rate and detect selection

  // defaults in pin-state order a..d; codes rise as the bandwidth narrows
  localparam logic [3:0][3:0] BW_DEF   = {BW_DEF_D, BW_DEF_C, BW_DEF_B, BW_DEF_A}; // (R8) (R18)
  localparam logic [3:0][6:0] SDET_DEF = {SDET_DEF_D, SDET_DEF_C, SDET_DEF_B, SDET_DEF_A}; // (R13)

  wire [7:0] ctrl_r  = rif.regs[ADR_CTRL[3:0]];
  wire [7:0] slice_r = rif.regs[ADR_SLICE[3:0]];
  wire [7:0] emph_r  = rif.regs[ADR_EMPH[3:0]];
  wire [7:0] swing_r = rif.regs[ADR_SWING[3:0]];

  // control and swing fields; bit 0 of the control flags is kept but drives nothing
  wire       ocoff_r  = ctrl_r[CTRL_OCOFF_BIT]; // (R1)
  wire       range_r  = ctrl_r[CTRL_RANGE_BIT]; // (R11)
  wire       mute_r   = ctrl_r[CTRL_MUTE_BIT];
  wire [1:0] swcode_r = swing_r[1:0];           // (R3)

  // an open pin reads as its internal pull: high pin up, low pin down
  // so an unwired board lands on source d without any register write
  wire pin_hi = BW_PIN_HI_OPEN ? 1'b1 : BW_PIN_HI; // (R10) (R15)
  wire pin_lo = BW_PIN_LO_OPEN ? 1'b0 : BW_PIN_LO; // (R10) (R15)

  // 00->a, 01->b, 11->c, 10->d
  wire [1:0] src = {pin_hi, pin_hi ^ pin_lo}; // (R7) (R8) (R13)

  // every source resolves its own code, so the pins only steer a final mux
  // and a pin change never waits on a register lookup
  wire [3:0][3:0] bw_cand;
  wire [3:0][6:0] sdet_cand;

  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : g_src
      wire [7:0] bw_r   = rif.regs[BW_BASE + s];   // (R8)
      wire [7:0] sdet_r = rif.regs[SDET_BASE + s]; // (R13)
      // a register takes over only while its custom bit is set
      wire       bw_own = bw_r[CUSTOM_BIT];        // (R9)
      wire       sd_own = sdet_r[CUSTOM_BIT];      // (R14)
      assign bw_cand[s]   = bw_own ? bw_r[3:0] : BW_DEF[s];     // (R6) (R9)
      assign sdet_cand[s] = sd_own ? sdet_r[6:0] : SDET_DEF[s]; // (R12) (R14)
    end
  endgenerate

  // selection is purely combinational; the flops below add one cycle
  wire [3:0] bw_eff   = bw_cand[src];   // (R7) (R17)
  wire [6:0] sdet_eff = sdet_cand[src]; // (R7) (R17)

  // codes above the top step clamp rather than wrap
  wire [3:0] emph_eff = (emph_r[3:0] > EMPH_MAX_DB) ? EMPH_MAX_DB : emph_r[3:0]; // (R5)

  // undefined code 10 falls back to the lowest swing
  wire [2:0] swing_sel =
    (swcode_r == SW_900) ? 3'h4 :
    (swcode_r == SW_600) ? 3'h2 : 3'h1; // (R3) (R4)

  // no hysteresis: the flag follows the comparison every cycle
  wire absent_d = SIG_LEVEL < sdet_eff; // (R16)

  // settings taken straight from the control and slice registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OFFSET_CANCEL_OFF <= 1'b0;
      SIGDET_RANGE_HI   <= 1'b0;
      OUTPUT_MUTE       <= 1'b0;
      SLICE_LEVEL_CODE  <= 8'h00;
    end else begin
      OFFSET_CANCEL_OFF <= ocoff_r; // (R1)
      SIGDET_RANGE_HI   <= range_r; // (R11)
      OUTPUT_MUTE       <= mute_r;
      SLICE_LEVEL_CODE  <= slice_r; // (R2)
    end
  end

  // output stage codes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EMPHASIS_CODE <= 4'h0;
      SWING_CODE    <= SW_300;
      SWING_SEL     <= 3'h1;
    end else begin
      EMPHASIS_CODE <= emph_eff;  // (R5)
      SWING_CODE    <= swcode_r;  // (R3)
      SWING_SEL     <= swing_sel; // (R4)
    end
  end

  // pin-steered codes and the detect comparison
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BW_CODE       <= 4'h0;
      SIGDET_CODE   <= 7'h00;
      SIGNAL_ABSENT <= 1'b0;
    end else begin
      BW_CODE       <= bw_eff;   // (R6)
      SIGDET_CODE   <= sdet_eff; // (R12)
      SIGNAL_ABSENT <= absent_d; // (R16)
    end
  end

endmodule // lacs_top

// ### pkg/lacs_pkg.sv
package lacs_pkg;

  // register map
  localparam int          NREG         = 12;
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_SLICE    = 8'h01;
  localparam logic [7:0]  ADR_EMPH     = 8'h02;
  localparam logic [7:0]  ADR_SWING    = 8'h03;
  localparam logic [7:0]  ADR_BW_A     = 8'h04;
  localparam logic [7:0]  ADR_BW_B     = 8'h05;
  localparam logic [7:0]  ADR_BW_C     = 8'h06;
  localparam logic [7:0]  ADR_BW_D     = 8'h07;
  localparam logic [7:0]  ADR_SDET_A   = 8'h08;
  localparam logic [7:0]  ADR_SDET_B   = 8'h09;
  localparam logic [7:0]  ADR_SDET_C   = 8'h0a;
  localparam logic [7:0]  ADR_SDET_D   = 8'h0b;
  localparam int          BW_BASE      = 4;
  localparam int          SDET_BASE    = 8;

  // value after reset of every register
  localparam logic [7:0]  REG_RST      = 8'h00;

  // writable bits per register, index = offset; reserved bits read zero
  localparam logic [NREG-1:0][7:0] REG_MASK = {
    8'hff, 8'hff, 8'hff, 8'hff,
    8'h8f, 8'h8f, 8'h8f, 8'h8f,
    8'h03, 8'h0f, 8'hff, 8'h0f};

  // field positions
  localparam int          CTRL_MUTE_BIT  = 3;
  localparam int          CTRL_RANGE_BIT = 2;
  localparam int          CTRL_OCOFF_BIT = 1;
  localparam int          CUSTOM_BIT     = 7;

  // default bandwidth codes per pin state a..d (2.2, 4.0, 6.5, 11.0 GHz)
  localparam logic [3:0]  BW_DEF_A     = 4'hf;
  localparam logic [3:0]  BW_DEF_B     = 4'h8;
  localparam logic [3:0]  BW_DEF_C     = 4'h5;
  localparam logic [3:0]  BW_DEF_D     = 4'h2;

  // swing codes
  localparam logic [1:0]  SW_300       = 2'h0;
  localparam logic [1:0]  SW_600       = 2'h1;
  localparam logic [1:0]  SW_900       = 2'h3;
  localparam logic [3:0]  EMPH_MAX_DB  = 4'h8;

  // serial slave
  localparam logic [6:0]  DEV_ADDR     = 7'h44;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;

  typedef logic [NREG-1:0][7:0] lacs_regs_t;

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_DEVADR = 10'h002,
    ST_ACKDEV = 10'h004,
    ST_REGADR = 10'h008,
    ST_ACKREG = 10'h010,
    ST_WDATA  = 10'h020,
    ST_ACKDAT = 10'h040,
    ST_RDATA  = 10'h080,
    ST_RACK   = 10'h100,
    ST_IGNORE = 10'h200
  } lacs_state_t;

endpackage

// ### pkg/lacs_reg_if.sv
`timescale 1ns/1ns
interface lacs_reg_if;
  import lacs_pkg::*;
  logic             wr_en;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  lacs_regs_t       regs;
  modport bank (input wr_en, wr_addr, wr_data, rd_addr, output rd_data, regs);
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data, regs);
endinterface

// ### test/lacs_chk.sv
`timescale 1ns/1ns
module lacs_chk
  import lacs_pkg::*;
(
  // clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // watched ports
  input wire logic       SCK,
  input wire logic [6:0] SIG_LEVEL,
  input wire logic       OFFSET_CANCEL_OFF,
  input wire logic [7:0] SLICE_LEVEL_CODE,
  input wire logic [3:0] EMPHASIS_CODE,
  input wire logic [1:0] SWING_CODE,
  input wire logic [2:0] SWING_SEL,
  input wire logic       SIGDET_RANGE_HI,
  input wire logic [6:0] SIGDET_CODE,
  input wire logic       SIGNAL_ABSENT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // writes land in the serial clock low phase, so settings never move while SCK is high
  AST_OCOFF_MOVE: assert property ($changed(OFFSET_CANCEL_OFF) |-> !SCK)
    else $error("offset cancel changed while SCK high");
  AST_SLICE_MOVE: assert property ($changed(SLICE_LEVEL_CODE) |-> !SCK)
    else $error("slice level changed while SCK high");
  AST_RANGE_MOVE: assert property ($changed(SIGDET_RANGE_HI) |-> !SCK)
    else $error("detect range changed while SCK high");
  AST_SW300: assert property (SWING_CODE == SW_300 |-> SWING_SEL == 3'h1)
    else $error("swing 300 select wrong");
  AST_SW600: assert property (SWING_CODE == SW_600 |-> SWING_SEL == 3'h2)
    else $error("swing 600 select wrong");
  AST_SW900: assert property (SWING_CODE == SW_900 |-> SWING_SEL == 3'h4)
    else $error("swing 900 select wrong");
  AST_EMPH_MAX: assert property (EMPHASIS_CODE <= EMPH_MAX_DB)
    else $error("emphasis code above limit");
  AST_ABSENT: assert property (($stable(SIG_LEVEL) && $stable(SIGDET_CODE)) [*3] |->
    SIGNAL_ABSENT == (SIG_LEVEL < SIGDET_CODE)) else $error("absent flag disagrees with threshold");
endmodule // lacs_chk

bind lacs_top lacs_chk i_chk (.CLK(CLK), .RST(RST), .SCK(SCK), .SIG_LEVEL(SIG_LEVEL),
  .OFFSET_CANCEL_OFF(OFFSET_CANCEL_OFF), .SLICE_LEVEL_CODE(SLICE_LEVEL_CODE), .EMPHASIS_CODE(EMPHASIS_CODE),
  .SWING_CODE(SWING_CODE), .SWING_SEL(SWING_SEL), .SIGDET_RANGE_HI(SIGDET_RANGE_HI),
  .SIGDET_CODE(SIGDET_CODE), .SIGNAL_ABSENT(SIGNAL_ABSENT));

// ### test/lacs_host.sv
`timescale 1ns/1ns
module lacs_host
  import lacs_pkg::*;
(
  // clock
  input  wire logic clk,
  // serial wires
  input  wire logic sda,
  output logic      sck,
  output logic      sda_m
);
  initial begin
    sck = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic edges(input logic c, input logic d);
    sda_m = d;
    tick(3);
    sck = c;
    tick(3);
  endtask
  // 6 clk per phase leaves room for the 2-stage sampling and the +3 ack timing
  task automatic bit_x(input logic b, output logic r);
    edges(1'b1, b);
    r = sda;
    tick(3);
    sck = 1'b0;
    tick(3);
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r, inout logic nak);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], a);
      r[i] = a;
    end
    bit_x(1'b1, a);
    nak = nak | a;
  endtask
  task automatic start();
    edges(1'b1, 1'b1);
    edges(1'b0, 1'b0);
  endtask
  task automatic stop();
    edges(1'b1, 1'b0);
    edges(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    wr_to(DEV_ADDR, a, d, nak);
  endtask
  // the slave address is an argument so the bench can try a foreign one
  task automatic wr_to(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    nak = 1'b0;
    start();
    byte_x({dev, 1'b0}, r, nak);
    byte_x(a, r, nak);
    byte_x(d, r, nak);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic k;
    nak = 1'b0;
    start();
    byte_x({DEV_ADDR, 1'b0}, r, nak);
    byte_x(a, r, nak);
    stop();
    start();
    byte_x({DEV_ADDR, 1'b1}, r, nak);
    k = nak;
    // the slot after the read byte is our own nack, not the device's answer
    byte_x(8'hff, d, nak);
    nak = k;
    stop();
  endtask
endmodule // lacs_host

// ### test/lacs_top_tb.sv
`timescale 1ns/1ns
module lacs_top_tb;
  import lacs_pkg::*;
  localparam logic [6:0] SD_A = 7'h00, SD_B = 7'h13, SD_C = 7'h46, SD_D = 7'h46;
  localparam logic [1:0] PS [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  localparam logic [3:0] BWD [4] = '{BW_DEF_A, BW_DEF_B, BW_DEF_C, BW_DEF_D};
  localparam logic [6:0] SDD [4] = '{SD_A, SD_B, SD_C, SD_D};
  localparam logic [3:0] BWC [4] = '{4'h0, 4'h3, 4'h9, 4'hf};
  localparam logic [6:0] SDC [4] = '{7'h7f, 7'h01, 7'h40, 7'h2a};
  localparam logic [1:0] SWC [3] = '{SW_300, SW_600, SW_900};
  localparam logic [2:0] SWS [3] = '{3'h1, 3'h2, 3'h4};
  logic       clk, rst, pin_hi, pin_lo, hi_open, lo_open, sda_oe, sda_o, sck, sda_m, ocoff, mute, rng, absent;
  logic       nk;
  logic [6:0] sig_level, sdet_code;
  logic [7:0] slice;
  logic [3:0] emph, bw_code;
  logic [1:0] sw_code;
  logic [2:0] sw_sel;
  wire        sda = sda_m & ~sda_oe;
  int         mismatches, compares, cyc;

  lacs_host i_host (.clk(clk), .sda(sda), .sck(sck), .sda_m(sda_m));
  lacs_top #(.SDET_DEF_A(SD_A), .SDET_DEF_B(SD_B), .SDET_DEF_C(SD_C), .SDET_DEF_D(SD_D)) i_dut (
    .CLK(clk), .RST(rst), .SCK(sck), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .BW_PIN_HI(pin_hi), .BW_PIN_LO(pin_lo), .BW_PIN_HI_OPEN(hi_open), .BW_PIN_LO_OPEN(lo_open),
    .SIG_LEVEL(sig_level), .OFFSET_CANCEL_OFF(ocoff), .SLICE_LEVEL_CODE(slice), .EMPHASIS_CODE(emph),
    .SWING_CODE(sw_code), .SWING_SEL(sw_sel), .OUTPUT_MUTE(mute), .BW_CODE(bw_code),
    .SIGDET_RANGE_HI(rng), .SIGDET_CODE(sdet_code), .SIGNAL_ABSENT(absent));

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    logic n;
    i_host.wr(a, d, n);
    chk("write ack", n, 1'b0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic n;
    i_host.rd(a, d, n);
    chk("read ack", n, 1'b0);
    chk("read data", d, e);
  endtask
  task automatic sel(input logic [1:0] p, input logic [1:0] op, input logic [3:0] bw, input logic [6:0] sd);
    {pin_hi, pin_lo} = p;
    {hi_open, lo_open} = op;
    repeat (3) @(negedge clk);
    chk("bw_code", bw_code, bw);
    chk("sdet_code", sdet_code, sd);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    {pin_hi, pin_lo, hi_open, lo_open} = 4'h0;
    sig_level = 7'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("swing_sel", sw_sel, 3'h1);
    chk("sda_o", sda_o, 1'b0);
    rchk(ADR_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) sel(PS[k], 2'b00, BWD[k], SDD[k]);
    wchk(ADR_CTRL, 8'hff);
    chk("ctrl outs", {ocoff, rng, mute}, 3'h7);
    rchk(ADR_CTRL, 8'h0f);
    wchk(ADR_CTRL, 8'h02);
    chk("ctrl outs", {ocoff, rng, mute}, 3'h4);
    wchk(ADR_SLICE, 8'ha5);
    chk("slice", slice, 8'ha5);
    // a foreign slave address gets no ack and writes nothing
    i_host.wr_to(DEV_ADDR ^ 7'h01, ADR_SLICE, 8'h3c, nk);
    chk("foreign ack", nk, 1'b1);
    chk("slice", slice, 8'ha5);
    wchk(ADR_EMPH, 8'h0c);
    chk("emph", emph, EMPH_MAX_DB);
    wchk(ADR_EMPH, 8'h05);
    chk("emph", emph, 4'h5);
    for (int k = 0; k < 3; k++) begin
      wchk(ADR_SWING, {6'h00, SWC[k]});
      chk("swing_sel", sw_sel, SWS[k]);
      chk("swing_code", sw_code, SWC[k]);
    end
    wchk(8'h0c, 8'h5a);
    rchk(8'h0c, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wchk(ADR_BW_A + 8'(k), {4'h8, BWC[k]});
      wchk(ADR_SDET_A + 8'(k), {1'b1, SDC[k]});
    end
    for (int k = 0; k < 4; k++) sel(PS[k], 2'b00, BWC[k], SDC[k]);
    // open pins read as hi=1 lo=0 whatever the driven level
    sel(2'b01, 2'b11, BWC[3], SDC[3]);
    sig_level = SDC[3] - 7'h01;
    repeat (4) @(negedge clk);
    chk("absent", absent, 1'b1);
    sig_level = SDC[3];
    repeat (4) @(negedge clk);
    chk("absent", absent, 1'b0);
    wchk(ADR_BW_D, 8'h0f);
    wchk(ADR_SDET_D, 8'h2a);
    sel(2'b01, 2'b11, BW_DEF_D, SD_D);
    tally_and_finish();
  end
endmodule // lacs_top_tb
